// ===== common/ecrf_params.svh
`ifndef ECRF_PARAMS_SVH
`define ECRF_PARAMS_SVH

// Record header size in bytes
`define ECRF_HDR_BYTES 16
// Size of each extension header in bytes
`define ECRF_EXT_BYTES 8
// Offset byte plus pad byte ahead of the frame
`define ECRF_PAD_BYTES 2
// Most extension headers carried by one record
`define ECRF_EXT_MAX 3
// Bit of a type byte that flags a following extension header
`define ECRF_MORE_BIT 7
// Base type code for an Ethernet record
`define ECRF_ETH_TYPE 7'h02
// Fill value of the unimplemented offset byte
`define ECRF_OFFSET_FILL 8'h00
// Fill value of the pad byte
`define ECRF_PAD_FILL 8'h00
// Output buffer depth in words
`define ECRF_FIFO_DEPTH 4
// Loss counter reset value
`define ECRF_LOSS_RESET 16'h0000

`endif

// ===== common/ecrf_pkg.sv
`default_nettype none
package ecrf_pkg;

   // Phases of one record on the output stream
   typedef enum logic [2:0] {
      ECRF_IDLE,
      ECRF_HDR,
      ECRF_EXT,
      ECRF_OFFS,
      ECRF_PAD,
      ECRF_PAY
   } ecrf_state_t;

   // Byte on the output stream
   typedef logic [7:0] ecrf_byte_t;

endpackage : ecrf_pkg
`default_nettype wire

// ===== hdl/ecrf_formatter.sv
// Operation
// - Type bit 7 set when extension headers follow
// - Ethernet record type bits 6:0 equal 2
// - Offset byte emitted; receiver ignores its value
// - One pad byte, then frame starts
// - Payload equals length minus 16, extensions, 2
// - Extension type bit 7 marks another following
// - Every extension header is eight bytes
// - Extension chaining independent of base record type
// - Record length field holds total record bytes
// - Loss counter counts drops since previous record
// - Wire length field holds on-link packet length
`timescale 1ns/1ps
`default_nettype none
`include "ecrf_params.svh"

// Small FIFO of flip-flops with valid/ready on both sides
module ecrf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH]; // Storage entries
   logic [AW-1:0] wr_q; // Write index
   logic [AW-1:0] rd_q; // Read index
   logic [AW:0] cnt_q; // Words held
   logic push; // Word taken in
   logic pop; // Word handed out

   // Honest full and empty flags
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];

   // Entry writes, one per storage word
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_entry
         always_ff @(posedge clock) begin
            if (push && (wr_q == AW'(gi))) begin
               mem_q[gi] <= in_data;
            end
         end
      end
   endgenerate

   // Write pointer with wrap
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
      end else if (push) begin
         wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
   end

   // Read pointer with wrap
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= '0;
      end else if (pop) begin
         rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
   end

   // Fill level
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else if (push && !pop) begin
         cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

endmodule : ecrf_fifo

// Builds Ethernet capture records as a byte stream
module ecrf_formatter
   import ecrf_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic desc_valid,
   output logic desc_ready,
   input wire logic [63:0] desc_timestamp,
   input wire logic [7:0] desc_flags,
   input wire logic [15:0] desc_wire_len,
   input wire logic [15:0] desc_frame_len,
   input wire logic [1:0] desc_ext_count,
   input wire logic [20:0] desc_ext_kind,
   input wire logic [167:0] desc_ext_body,
   input wire logic loss_event,
   input wire logic frame_valid,
   output logic frame_ready,
   input wire logic [7:0] frame_data,
   output logic rec_valid,
   input wire logic rec_ready,
   output logic [7:0] rec_data,
   output logic rec_last,
   output logic busy
);
   localparam int EXTW = 64 * `ECRF_EXT_MAX;

   ecrf_state_t state_q; // Record phase
   logic [15:0] cnt_q; // Bytes left in phase, minus one
   logic [127:0] hdr_q; // Header shift register
   logic [EXTW-1:0] ext_q; // Extension shift register
   logic [1:0] ext_n_q; // Extension count of record
   logic [15:0] len_q; // Frame length of record
   logic [15:0] loss_q; // Drops since last record
   logic [EXTW-1:0] ext_flat; // Extensions laid out in order
   logic [15:0] rlen; // Total record length
   logic [7:0] type_byte; // Record type byte
   logic [15:0] loss_field; // Loss value for this record
   logic take; // Descriptor accepted
   logic fill_valid; // Byte offered to buffer
   logic fill_ready; // Buffer has room
   logic fire; // Byte moved into buffer
   ecrf_byte_t fill_data; // Byte offered
   logic fill_last; // Last byte of record
   logic phase_end; // Final byte of phase moves

   // Descriptor taken only between records
   assign desc_ready = (state_q == ECRF_IDLE);
   assign take = desc_valid && desc_ready;
   assign busy = (state_q != ECRF_IDLE);

   // Extension headers in chain order, first at the top
   genvar ge;
   generate
      for (ge = 0; ge < `ECRF_EXT_MAX; ge++) begin : g_ext
         logic more; // Another header follows this one
         assign more = (2'(ge + 1) < desc_ext_count);
         assign ext_flat[EXTW-1-64*ge -: 64] = {more, desc_ext_kind[7*ge +: 7],
                                                desc_ext_body[56*ge +: 56]};
      end
   endgenerate

   // Type byte: chain flag over the Ethernet code
   assign type_byte = {(desc_ext_count != 2'd0), `ECRF_ETH_TYPE};

   // Total bytes handed to the host for this record
   assign rlen = 16'(`ECRF_HDR_BYTES + `ECRF_PAD_BYTES) + {desc_ext_count, 3'b000}
                 + desc_frame_len;

   // Drop arriving with the take still lands in this record
   assign loss_field = (loss_event && loss_q != 16'hffff) ? loss_q + 16'h0001 : loss_q;

   // Drop counter, cleared when a record takes its value
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         loss_q <= `ECRF_LOSS_RESET;
      end else if (take) begin
         loss_q <= `ECRF_LOSS_RESET;
      end else if (loss_event && loss_q != 16'hffff) begin
         loss_q <= loss_q + 16'h0001;
      end
   end

   // Byte offered to the buffer in each phase
   always_comb begin
      fill_valid = 1'b0;
      fill_data = 8'h00;
      fill_last = 1'b0;
      case (state_q)
         ECRF_IDLE: begin
            fill_valid = 1'b0;
         end
         ECRF_HDR: begin
            fill_valid = 1'b1;
            fill_data = hdr_q[127:120];
         end
         ECRF_EXT: begin
            fill_valid = 1'b1;
            fill_data = ext_q[EXTW-1 -: 8];
         end
         ECRF_OFFS: begin
            fill_valid = 1'b1;
            fill_data = `ECRF_OFFSET_FILL;
         end
         ECRF_PAD: begin
            fill_valid = 1'b1;
            fill_data = `ECRF_PAD_FILL;
            fill_last = (len_q == 16'h0000);
         end
         ECRF_PAY: begin
            fill_valid = frame_valid;
            fill_data = frame_data;
            fill_last = (cnt_q == 16'h0000);
         end
         default: begin
            fill_valid = 1'b0;
         end
      endcase
   end

   // Frame bytes drawn only while the buffer has room
   assign frame_ready = (state_q == ECRF_PAY) && fill_ready;
   assign fire = fill_valid && fill_ready;
   assign phase_end = fire && (cnt_q == 16'h0000);

   // Header and extension shift registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         hdr_q <= '0;
         ext_q <= '0;
      end else if (take) begin
         hdr_q <= {desc_timestamp, type_byte, desc_flags, rlen, loss_field,
                   desc_wire_len};
         ext_q <= ext_flat;
      end else if (fire && state_q == ECRF_HDR) begin
         hdr_q <= {hdr_q[119:0], 8'h00};
      end else if (fire && state_q == ECRF_EXT) begin
         ext_q <= {ext_q[EXTW-9:0], 8'h00};
      end
   end

   // Per-record lengths held for the phase sequence
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_n_q <= 2'd0;
         len_q <= 16'h0000;
      end else if (take) begin
         ext_n_q <= desc_ext_count;
         len_q <= desc_frame_len;
      end
   end

   // Phase sequence: header, extensions, offset, pad, frame
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ECRF_IDLE;
         cnt_q <= 16'h0000;
      end else begin
         case (state_q)
            ECRF_IDLE: begin
               if (take) begin
                  state_q <= ECRF_HDR;
                  cnt_q <= 16'(`ECRF_HDR_BYTES - 1);
               end
            end
            ECRF_HDR: begin
               if (phase_end && ext_n_q != 2'd0) begin
                  state_q <= ECRF_EXT;
                  cnt_q <= {11'h000, ext_n_q, 3'b000} - 16'h0001;
               end else if (phase_end) begin
                  state_q <= ECRF_OFFS;
                  cnt_q <= 16'h0000;
               end else if (fire) begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            ECRF_EXT: begin
               if (phase_end) begin
                  state_q <= ECRF_OFFS;
                  cnt_q <= 16'h0000;
               end else if (fire) begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            ECRF_OFFS: begin
               if (fire) begin
                  state_q <= ECRF_PAD;
                  cnt_q <= 16'h0000;
               end
            end
            ECRF_PAD: begin
               if (fire && len_q == 16'h0000) begin
                  state_q <= ECRF_IDLE;
               end else if (fire) begin
                  state_q <= ECRF_PAY;
                  cnt_q <= len_q - 16'h0001;
               end
            end
            ECRF_PAY: begin
               if (phase_end) begin
                  state_q <= ECRF_IDLE;
               end else if (fire) begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: begin
               state_q <= ECRF_IDLE;
            end
         endcase
      end
   end

   // Output buffer; host-side stall reaches the frame source
   ecrf_fifo #(
      .WIDTH(9),
      .DEPTH(`ECRF_FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset_n(reset_n),
      .in_valid(fill_valid),
      .in_ready(fill_ready),
      .in_data({fill_last, fill_data}),
      .out_valid(rec_valid),
      .out_ready(rec_ready),
      .out_data({rec_last, rec_data})
   );

endmodule : ecrf_formatter
`default_nettype wire

// ===== sim/ecrf_formatter_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the record byte stream at the formatter's ports
module ecrf_formatter_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic desc_valid,
   input wire logic desc_ready,
   input wire logic [1:0] desc_ext_count,
   input wire logic frame_ready,
   input wire logic rec_valid,
   input wire logic rec_ready,
   input wire logic [7:0] rec_data,
   input wire logic rec_last,
   input wire logic busy
);
   logic [15:0] cnt_q; // Index of the byte on offer
   logic [15:0] rlen_q; // Length field seen on the stream
   logic [1:0] n_q [2]; // Extension counts of records in flight
   logic wp_q; // Slot for the next take
   logic rp_q; // Slot of the record on the stream
   logic hs; // Byte accepted
   logic [15:0] n8; // Extension bytes of the record on the stream
   assign hs = rec_valid && rec_ready;
   assign n8 = {11'h000, n_q[rp_q], 3'h0};
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Two slots, since a new take may precede the old record's drain
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 16'h0000;
         rlen_q <= 16'h0000;
         n_q[0] <= 2'h0;
         n_q[1] <= 2'h0;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
      end else begin
         if (desc_valid && desc_ready) begin
            n_q[wp_q] <= desc_ext_count;
            wp_q <= !wp_q;
         end
         if (hs) begin
            cnt_q <= rec_last ? 16'h0000 : cnt_q + 16'h0001;
            rp_q <= rec_last ? !rp_q : rp_q;
         end
         if (hs && cnt_q == 16'h000a) rlen_q[15:8] <= rec_data;
         if (hs && cnt_q == 16'h000b) rlen_q[7:0] <= rec_data;
      end
   end
   sequence taken;
      desc_valid && desc_ready;
   endsequence
   sequence header_only;
      !frame_ready [*8];
   endsequence
   take_starts_a: assert property (taken |=> busy && !desc_ready)
      else $error("take did not start a record");
   type_flag_a: assert property (rec_valid && cnt_q == 16'h0008 |-> rec_data[7] == (n_q[rp_q] != 2'h0))
      else $error("type flag wrong");
   type_code_a: assert property (rec_valid && cnt_q == 16'h0008 |-> rec_data[6:0] == 7'h02)
      else $error("type code wrong");
   ext_chain_a: assert property (rec_valid && cnt_q >= 16'h0010 && cnt_q < 16'h0010 + n8 && cnt_q[2:0] == 3'h0
      |-> rec_data[7] == (cnt_q < 16'h0008 + n8))
      else $error("extension chain flag wrong");
   pad_zero_a: assert property (rec_valid && cnt_q == 16'h0011 + n8 |-> rec_data == 8'h00)
      else $error("pad byte wrong");
   last_index_a: assert property (rec_valid && rec_last |-> cnt_q == rlen_q - 16'h0001)
      else $error("last byte off length");
   byte_hold_a: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_last))
      else $error("offered byte changed");
   frame_wait_a: assert property (taken |=> header_only)
      else $error("frame drawn in header");
endmodule : ecrf_formatter_checker
bind ecrf_formatter ecrf_formatter_checker chk (.clock, .reset_n, .desc_valid, .desc_ready, .desc_ext_count,
   .frame_ready, .rec_valid, .rec_ready, .rec_data, .rec_last, .busy);
`default_nettype wire

// ===== sim/ecrf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host stream buffer: stores record bytes at a chosen pace
module ecrf_host_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic rec_valid,
   output logic rec_ready,
   input wire logic [7:0] rec_data,
   input wire logic rec_last,
   input wire logic [1:0] pace
);
   logic [8:0] q[$]; // Stored bytes with last flag
   logic [1:0] t_q = 2'h0; // Pace divider
   initial rec_ready = 1'b0;
   // Pace 0 prompt, 1 one in four, 2 stalled; offset byte stored, never read
   always @(posedge clock) begin
      if (rec_valid && rec_ready) q.push_back({rec_last, rec_data});
      t_q <= #1 t_q + 2'h1;
      rec_ready <= #1 reset_n && (pace == 2'h0 || (pace == 2'h1 && t_q == 2'h0));
   end
endmodule : ecrf_host_model
`default_nettype wire

// ===== sim/ecrf_formatter_test.sv
`timescale 1ns/1ps
`default_nettype none
// Record formatter bench
module ecrf_formatter_test;
   logic clock, reset_n, desc_valid, desc_ready, loss_event, frame_valid, frame_ready;
   logic rec_valid, rec_ready, rec_last, busy;
   logic [63:0] desc_timestamp;
   logic [7:0] desc_flags, frame_data, rec_data;
   logic [15:0] desc_wire_len, desc_frame_len, rl;
   logic [1:0] desc_ext_count, pace;
   logic [20:0] desc_ext_kind;
   logic [167:0] desc_ext_body;
   logic [9:0] exp_q[$]; // Expected bytes: skip flag, last flag, data
   int err_total, checks, fk, lost;
   ecrf_formatter dut (.clock, .reset_n, .desc_valid, .desc_ready, .desc_timestamp, .desc_flags, .desc_wire_len,
      .desc_frame_len, .desc_ext_count, .desc_ext_kind, .desc_ext_body, .loss_event, .frame_valid, .frame_ready,
      .frame_data, .rec_valid, .rec_ready, .rec_data, .rec_last, .busy);
   ecrf_host_model host (.clock, .reset_n, .rec_valid, .rec_ready, .rec_data, .rec_last, .pace);
   assign frame_data = 8'(fk) ^ 8'h5a; // Frame byte pattern
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) if (frame_valid && frame_ready) fk <= #1 fk + 1;
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // Offers one descriptor, queues its expected bytes, waits for the take
   task automatic start(input int n, input int len);
      int w;
      @(posedge clock);
      #1;
      desc_timestamp = 64'h0102030405060708 + 64'(len);
      desc_wire_len = 16'(len + 4);
      desc_frame_len = 16'(len);
      desc_ext_count = 2'(n);
      desc_valid = 1'b1;
      rl = 16'(18 + 8 * n + len);
      for (int i = 0; i < 8; i++) exp_q.push_back({2'h0, desc_timestamp[63 - 8 * i -: 8]});
      exp_q.push_back({2'h0, n != 0, 7'h02});
      exp_q.push_back({2'h0, desc_flags});
      exp_q.push_back({2'h0, rl[15:8]});
      exp_q.push_back({2'h0, rl[7:0]});
      exp_q.push_back({2'h0, 8'(lost >> 8)});
      exp_q.push_back({2'h0, 8'(lost)});
      exp_q.push_back({2'h0, desc_wire_len[15:8]});
      exp_q.push_back({2'h0, desc_wire_len[7:0]});
      for (int i = 0; i < n; i++) begin
         exp_q.push_back({2'h0, i < n - 1, 7'(8'h11 + i)});
         for (int b = 0; b < 7; b++) exp_q.push_back({2'h0, 8'(8'h20 + 8 * i + b)});
      end
      exp_q.push_back(10'h200);
      exp_q.push_back({1'b0, len == 0, 8'h00});
      for (int j = 0; j < len; j++) exp_q.push_back({1'b0, j == len - 1, 8'(fk + j) ^ 8'h5a});
      for (w = 0; desc_ready !== 1'b1 && w < 500; w++) @(posedge clock) #1;
      @(posedge clock);
      #1;
      desc_valid = 1'b0;
      lost = 0;
      chk(w < 500, "descriptor not taken");
   endtask : start
   // Waits for all queued bytes at the host and compares those without the skip flag
   task automatic finish;
      for (int w = 0; host.q.size() < exp_q.size() && w < 2000; w++) @(posedge clock);
      #1;
      chk(host.q.size() == exp_q.size(), "record length");
      foreach (exp_q[i]) if (!exp_q[i][9]) chk(host.q[i] === exp_q[i][8:0], "record byte");
      exp_q.delete();
      host.q.delete();
   endtask : finish
   task automatic t_plain;
      pace = 2'h0;
      start(0, 1);
      finish;
      $display("test plain done");
   endtask : t_plain
   task automatic t_chain;
      pace = 2'h1;
      repeat (3) begin
         @(posedge clock) #1 loss_event = 1'b1;
         lost++;
         @(posedge clock) #1 loss_event = 1'b0;
      end
      start(3, 5);
      finish;
      $display("test chain done");
   endtask : t_chain
   task automatic t_back;
      pace = 2'h0;
      start(1, 0);
      start(2, 3);
      // Frame source pauses across the start of the payload phase
      repeat (30) @(posedge clock);
      #1;
      frame_valid = 1'b0;
      repeat (10) @(posedge clock);
      #1;
      chk(frame_ready === 1'b1 && busy === 1'b1 && rec_valid === 1'b0, "frame gap not waited");
      frame_valid = 1'b1;
      finish;
      $display("test back to back done");
   endtask : t_back
   task automatic t_stall;
      pace = 2'h2;
      start(2, 8);
      repeat (40) @(posedge clock);
      #1;
      chk(busy === 1'b1 && frame_ready === 1'b0 && host.q.size() == 0, "full buffer did not stall");
      pace = 2'h0;
      finish;
      $display("test stall done");
   endtask : t_stall
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   initial begin
      #100000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done;
   end
   initial begin
      {reset_n, desc_valid, loss_event, pace, desc_timestamp, desc_wire_len, desc_frame_len} = '0;
      {desc_ext_count, err_total, checks, fk, lost} = '0;
      desc_flags = 8'h3c;
      frame_valid = 1'b1;
      for (int i = 0; i < 3; i++) begin
         desc_ext_kind[7 * i +: 7] = 7'(8'h11 + i);
         for (int b = 0; b < 7; b++) desc_ext_body[56 * i + 55 - 8 * b -: 8] = 8'(8'h20 + 8 * i + b);
      end
      repeat (16) @(posedge clock);
      #1;
      reset_n = 1'b1;
      t_plain;
      t_chain;
      t_back;
      t_stall;
      test_done;
   end
endmodule : ecrf_formatter_test
`default_nettype wire
